/* core/decp_counter.sv */
`timescale 1ns/1ns
`default_nettype none

module decp_counter #(
  parameter int WIDTH = 40,
  parameter int DELAY = 5
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [2:0] count_control,
  input wire logic pin_function,
  input wire logic [1:0] priv_level,
  input wire logic [1:0] occurrences,
  input wire logic condition,
  input wire logic pin_owned,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] count,
  output logic indication_pin
);

  // ****************************************************************
  // Count qualification
  // ****************************************************************
  wire logic is_user;
  wire logic priv_ok;
  wire logic duration;
  wire logic [1:0] amount;
  wire logic [WIDTH:0] sum;
  wire logic incremented;
  wire logic overflow;
  wire logic raw_pin;
  logic [DELAY-1:0] pin_pipe;

  assign is_user = (priv_level == decp_pkg::PRIV_USER);
  assign priv_ok = is_user ? count_control[decp_pkg::CC_USER_BIT]
                           : count_control[decp_pkg::CC_KERNEL_BIT];
  assign duration = count_control[decp_pkg::CC_DURATION_BIT];
  // Duration adds one per clock while condition is high; occurrences add up to three per clock.
  assign amount = !priv_ok ? 2'h0
                : duration ? {1'b0, condition}
                : occurrences;
  assign sum = {1'b0, count} + {{(WIDTH - 1){1'b0}}, amount};
  assign incremented = (amount != 2'h0);
  assign overflow = sum[WIDTH];
  // With pin_function low the pin pulses once per clock whatever the amount added; with it high the pin shows overflow.
  assign raw_pin = pin_function ? overflow : incremented;

  // ****************************************************************
  // Counter and pin pipeline
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= '0;
    end else if (clk_en) begin
      if (load) begin
        count <= load_value;
      end else begin
        count <= sum[WIDTH-1:0];
      end
    end
  end

  // The pipeline models latching and buffering before the pin leaves.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_pipe <= '0;
    end else if (clk_en) begin
      pin_pipe <= {pin_pipe[DELAY-2:0], raw_pin & !load};
    end
  end

  // While a debugger owns the pin the counter signal is withheld.
  assign indication_pin = pin_pipe[DELAY-1] & !pin_owned;

endmodule

`default_nettype wire

/* core/decp_unit.sv */
`timescale 1ns/1ns
`default_nettype none

module decp_unit #(
  parameter int WIDTH = decp_pkg::COUNTER_WIDTH,
  parameter int DELAY = decp_pkg::OVERFLOW_PIN_DELAY_CLOCKS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [1:0] current_privilege_level,
  input wire logic access_valid,
  input wire logic access_write,
  input wire logic [1:0] access_select,
  input wire logic [63:0] access_wdata,
  output logic [63:0] access_rdata,
  output logic access_fault,
  output logic access_done,
  input wire logic [1:0] occurrences_zero,
  input wire logic condition_zero,
  input wire logic [1:0] occurrences_one,
  input wire logic condition_one,
  input wire logic breakpoint_mode,
  input wire logic [1:0] breakpoint_match,
  output logic [decp_pkg::EVENT_CODE_WIDTH-1:0] event_code_zero,
  output logic [decp_pkg::EVENT_CODE_WIDTH-1:0] event_code_one,
  output logic indication_pin_zero,
  output logic indication_pin_one
);

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic [31:0] event_control_select;
  logic breakpoint_owned;
  wire logic privileged;
  wire logic hit_ctrl;
  wire logic hit_zero;
  wire logic hit_one;
  wire logic mapped;
  wire logic take;
  wire logic [WIDTH-1:0] count_zero;
  wire logic [WIDTH-1:0] count_one;
  wire logic [WIDTH-1:0] load_value;
  wire logic pin_zero;
  wire logic pin_one;
  wire logic [2:0] count_control_zero;
  wire logic [2:0] count_control_one;
  wire logic pin_function_zero;
  wire logic pin_function_one;

  assign privileged = (current_privilege_level == decp_pkg::PRIV_KERNEL);
  assign hit_ctrl = (access_select == decp_pkg::SEL_CONTROL);
  assign hit_zero = (access_select == decp_pkg::SEL_COUNTER_ZERO);
  assign hit_one = (access_select == decp_pkg::SEL_COUNTER_ONE);
  assign mapped = hit_ctrl | hit_zero | hit_one;
  assign take = clk_en & access_valid & privileged & mapped;
  assign load_value = access_wdata[WIDTH-1:0];

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  assign event_code_zero = event_control_select[
    decp_pkg::EVENT_CODE_ZERO_LSB +: decp_pkg::EVENT_CODE_WIDTH];
  assign event_code_one = event_control_select[
    decp_pkg::EVENT_CODE_ONE_LSB +: decp_pkg::EVENT_CODE_WIDTH];
  assign count_control_zero = event_control_select[
    decp_pkg::COUNT_CONTROL_ZERO_LSB +: decp_pkg::COUNT_CONTROL_WIDTH];
  assign count_control_one = event_control_select[
    decp_pkg::COUNT_CONTROL_ONE_LSB +: decp_pkg::COUNT_CONTROL_WIDTH];
  assign pin_function_zero =
    event_control_select[decp_pkg::PIN_FUNCTION_ZERO_BIT];
  assign pin_function_one =
    event_control_select[decp_pkg::PIN_FUNCTION_ONE_BIT];

  // ****************************************************************
  // Registers
  // ****************************************************************
  // The whole register is written at once, so partial updates need
  // a read-modify-write by software.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      event_control_select <= decp_pkg::CTRL_RESET;
    end else if (take & access_write & hit_ctrl) begin
      event_control_select <=
        access_wdata[31:0] & decp_pkg::CTRL_WRITE_MASK;
    end
  end

  // Pins start in counter signalling; a debugger can take them after.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      breakpoint_owned <= 1'b0;
    end else if (clk_en) begin
      breakpoint_owned <= breakpoint_mode;
    end
  end

  // Read data and completion are registered, one cycle after the request; read data only for a taken read.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      access_rdata <= 64'h0;
      access_fault <= 1'b0;
      access_done <= 1'b0;
    end else if (clk_en) begin
      access_done <= access_valid;
      access_fault <= access_valid & !(privileged & mapped);
      if (take & !access_write) begin
        access_rdata <= hit_ctrl ? {32'h0, event_control_select}
                      : hit_zero ? {24'h0, count_zero}
                      : {24'h0, count_one};
      end
    end
  end

  // ****************************************************************
  // Counters
  // ****************************************************************
  decp_counter #(
    .WIDTH(WIDTH),
    .DELAY(DELAY)
  ) u_counter_zero (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .count_control(count_control_zero),
    .pin_function(pin_function_zero),
    .priv_level(current_privilege_level),
    .occurrences(occurrences_zero),
    .condition(condition_zero),
    .pin_owned(breakpoint_owned),
    .load(take & access_write & hit_zero),
    .load_value(load_value),
    .count(count_zero),
    .indication_pin(pin_zero)
  );

  decp_counter #(
    .WIDTH(WIDTH),
    .DELAY(DELAY)
  ) u_counter_one (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .count_control(count_control_one),
    .pin_function(pin_function_one),
    .priv_level(current_privilege_level),
    .occurrences(occurrences_one),
    .condition(condition_one),
    .pin_owned(breakpoint_owned),
    .load(take & access_write & hit_one),
    .load_value(load_value),
    .count(count_one),
    .indication_pin(pin_one)
  );

  // Breakpoint matches replace counter signalling while owned.
  assign indication_pin_zero = breakpoint_owned ? breakpoint_match[0]
                                                : pin_zero;
  assign indication_pin_one = breakpoint_owned ? breakpoint_match[1]
                                               : pin_one;

endmodule

`default_nettype wire

/* pkg/decp_pkg.sv */
package decp_pkg;

  // ****************************************************************
  // Register selection codes for the model-specific access port
  // ****************************************************************
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_COUNTER_ZERO = 2'h1;
  localparam logic [1:0] SEL_COUNTER_ONE = 2'h2;

  // ****************************************************************
  // Field layout of the control register
  // ****************************************************************
  localparam int CTRL_WIDTH = 32;
  localparam int COUNTER_WIDTH = 40;
  localparam int EVENT_CODE_WIDTH = 6;
  localparam int COUNT_CONTROL_WIDTH = 3;
  localparam int EVENT_CODE_ZERO_LSB = 0;
  localparam int COUNT_CONTROL_ZERO_LSB = 6;
  localparam int PIN_FUNCTION_ZERO_BIT = 9;
  localparam int EVENT_CODE_ONE_LSB = 16;
  localparam int COUNT_CONTROL_ONE_LSB = 22;
  localparam int PIN_FUNCTION_ONE_BIT = 25;
  localparam int CC_KERNEL_BIT = 0;
  localparam int CC_USER_BIT = 1;
  localparam int CC_DURATION_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [39:0] COUNTER_RESET = 40'h00_0000_0000;

  // Writable bits of the control register; the rest read as zero.
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h03ff_03ff;

  // ****************************************************************
  // Privilege levels and timing
  // ****************************************************************
  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [1:0] PRIV_USER = 2'h3;
  localparam int OVERFLOW_PIN_DELAY_CLOCKS = 5;
  localparam int MAX_OCCURRENCES = 2;

endpackage

/* verif/decp_pin_observer.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Far-side observer: tallies the clocks in which each pin is high.
// ****
module decp_pin_observer (
  input wire logic clk,
  input wire logic pin_zero,
  input wire logic pin_one,
  output int high_zero,
  output int high_one
);
  initial begin
    high_zero = 0;
    high_one = 0;
  end
  always @(posedge clk) begin
    high_zero <= high_zero + int'(pin_zero === 1'b1);
    high_one <= high_one + int'(pin_one === 1'b1);
  end
endmodule
`default_nettype wire

/* verif/decp_unit_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module decp_unit_bench;
  localparam int DLY = 5;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic av = 1'b0, aw = 1'b0, cnd0 = 1'b0, cnd1 = 1'b0, bpm = 1'b0;
  logic ce = 1'b1;
  logic [1:0] lvl = 2'h0, asel = 2'h0, occ1 = 2'h0, bpx = 2'h0;
  logic [1:0] occ0 = 2'h0;
  logic [63:0] awd = '0, ard, q;
  logic afl, adn, pin0, pin1, en;
  logic [5:0] ev0, ev1;
  logic [31:0] r;
  logic [65:0] e;
  logic [65:0] expq[$];
  int ho, hz, h, fails = 0, checks = 0;
  always #5 clk = ~clk;
  decp_unit #(.DELAY(DLY)) decp_unit_i (.clk(clk), .resetn(resetn),
    .clk_en(ce), .current_privilege_level(lvl), .access_valid(av),
    .access_write(aw), .access_select(asel), .access_wdata(awd),
    .access_rdata(ard), .access_fault(afl), .access_done(adn),
    .occurrences_zero(occ0), .condition_zero(cnd0),
    .occurrences_one(occ1), .condition_one(cnd1), .breakpoint_mode(bpm),
    .breakpoint_match(bpx), .event_code_zero(ev0), .event_code_one(ev1),
    .indication_pin_zero(pin0), .indication_pin_one(pin1));
  decp_pin_observer decp_pin_observer_i (.clk(clk), .pin_zero(pin0),
    .pin_one(pin1), .high_zero(hz), .high_one(ho));
  task automatic final_report();
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(string nm, logic [63:0] x, logic [63:0] g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic acc(logic w, logic [1:0] s, logic [63:0] d, logic f,
      logic [63:0] x);
    int n = 0;
    @(negedge clk);
    av = 1'b1;
    aw = w;
    asel = s;
    awd = d;
    expq.push_back({!w && !f, f, x});
    @(negedge clk);
    av = 1'b0;
    while (expq.size() != 0) begin
      n++;
      if (n > 4) begin
        fails++;
        final_report();
      end
      @(negedge clk);
    end
  endtask
  always @(negedge clk) begin
    if (adn === 1'b1) begin
      if (expq.size() == 0) begin
        cmp("access_done", 64'h0, 64'h1);
      end else begin
        e = expq.pop_front();
        cmp("access_fault", 64'(e[64]), 64'(afl));
        if (e[65]) cmp("access_rdata", e[63:0], ard);
      end
    end
  end
  initial begin
    void'($urandom(28));
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    acc(0, 0, 0, 0, 0);
    acc(0, 1, 0, 0, 0);
    acc(0, 3, 0, 1, 0);
    lvl = 2'h3;
    acc(1, 0, 64'hffff_ffff, 1, 0);
    lvl = 2'h0;
    acc(0, 0, 0, 0, 0);
    r = $urandom();
    acc(1, 0, 64'(r), 0, 0);
    acc(0, 0, 0, 0, 64'(r & 32'h03ff_03ff));
    q = {$urandom(), $urandom()};
    acc(1, 2, q, 0, 0);
    acc(0, 2, 0, 0, 64'(q[39:0]));
    for (int c = 0; c < 16; c++) begin
      acc(1, 0, 0, 0, 0);
      acc(1, 2, 0, 0, 0);
      acc(1, 0, {39'h0, c[2:0], 22'h0}, 0, 0);
      h = ho;
      lvl = c[3] ? 2'h3 : 2'h0;
      occ1 = 2'h2;
      cnd1 = 1'b1;
      repeat (3) @(negedge clk);
      occ1 = 2'h0;
      cnd1 = 1'b0;
      lvl = 2'h0;
      repeat (7) @(negedge clk);
      en = c[3] ? c[1] : c[0];
      cmp("pin_one_high", en ? 64'h3 : 64'h0, 64'(ho - h));
      acc(0, 2, 0, 0, en ? (c[2] ? 64'h3 : 64'h6) : 64'h0);
    end
    acc(1, 1, 64'h00ff_ffff_fffe, 0, 0);
    acc(1, 0, 64'h0000_03c0, 0, 0);
    for (int i = 0; i < 10; i++) begin
      cnd0 = (i < 3);
      cmp("pin_zero", 64'(i == 1 + DLY), 64'(pin0));
      @(negedge clk);
    end
    acc(0, 1, 0, 0, 64'h1);
    bpm = 1'b1;
    bpx = 2'h3;
    repeat (3) @(negedge clk);
    cmp("pins_breakpoint", 64'h3, {62'h0, pin1, pin0});
    bpm = 1'b0;
    bpx = 2'h0;
    repeat (3) @(negedge clk);
    cmp("pins_counting", 64'h0, {62'h0, pin1, pin0});
    // Counter zero counts occurrences; a low clock enable must freeze it.
    acc(1, 1, 0, 0, 0);
    acc(1, 0, 64'h0000_00c0, 0, 0);
    h = hz;
    ce = 1'b0;
    occ0 = 2'h2;
    repeat (4) @(negedge clk);
    ce = 1'b1;
    occ0 = 2'h1;
    @(negedge clk);
    occ0 = 2'h0;
    repeat (6) @(negedge clk);
    cmp("pin_zero_high", 64'h1, 64'(hz - h));
    acc(0, 1, 0, 0, 64'h1);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    acc(0, 0, 0, 0, 0);
    final_report();
  end
endmodule
`default_nettype wire

/* verif/decp_unit_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Access handshake and control-field properties.
// ****
module decp_unit_checker #(
  parameter int DELAY = 5
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [1:0] current_privilege_level,
  input wire logic access_valid,
  input wire logic access_write,
  input wire logic [1:0] access_select,
  input wire logic [63:0] access_wdata,
  input wire logic [63:0] access_rdata,
  input wire logic access_fault,
  input wire logic access_done,
  input wire logic [5:0] event_code_zero,
  input wire logic [5:0] event_code_one,
  input wire logic indication_pin_zero,
  input wire logic indication_pin_one
);
  wire logic ok_acc = clk_en && access_valid &&
    current_privilege_level == 2'h0 && access_select != 2'h3;
  wire logic ctl_wr = ok_acc && access_write && access_select == 2'h0;
  wire logic ctl_rd = ok_acc && !access_write && access_select == 2'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_done_follows: assert property (clk_en && access_valid |=> access_done)
    else $error("access_done missing after request");
  a_no_stray: assert property (clk_en && !access_valid |=> !access_done)
    else $error("access_done without request");
  a_fault_refused: assert property (clk_en && access_valid && !ok_acc |=>
    access_fault) else $error("refused access not flagged");
  a_fault_clear: assert property (ok_acc |=> !access_fault)
    else $error("legal access flagged");
  a_freeze_hold: assert property (!clk_en |=>
    $stable(access_done) && $stable(access_fault) &&
    $stable(access_rdata))
    else $error("access outputs moved while clock enable low");
  a_code_zero: assert property (ctl_wr |=>
    event_code_zero == $past(access_wdata[5:0]))
    else $error("event_code_zero not loaded");
  a_code_one: assert property (ctl_wr |=>
    event_code_one == $past(access_wdata[21:16]))
    else $error("event_code_one not loaded");
  a_read_masked: assert property (ctl_rd |=>
    (access_rdata & ~64'h0000_0000_03ff_03ff) == 64'h0 &&
    access_rdata[5:0] == event_code_zero)
    else $error("control read shows unwritable bits");
  a_reset_clear: assert property ($rose(resetn) |->
    event_code_zero == 6'h0 && event_code_one == 6'h0 &&
    !indication_pin_zero && !indication_pin_one)
    else $error("state not cleared by reset");
  c_fault: cover property (access_fault);
  c_pin_zero: cover property (indication_pin_zero);
  c_pin_one: cover property (indication_pin_one);
endmodule
bind decp_unit decp_unit_checker #(.DELAY(DELAY)) decp_unit_checker_i (.*);
`default_nettype wire
